// file: mwd_pkg.sv
package mwd_pkg;
   // Clock and low-power sample base period
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned LP_BASE_NS         = 1000;
   localparam int unsigned LP_BASE_CYCLES_DEF = (LP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_FILTER   = 8'h1D;
   localparam logic [7:0] IDX_LP       = 8'h1E;
   localparam logic [7:0] IDX_THR      = 8'h1F;
   localparam logic [7:0] IDX_XTHR     = 8'h20;
   localparam logic [7:0] IDX_YTHR     = 8'h21;
   localparam logic [7:0] IDX_ZTHR     = 8'h22;
   localparam logic [7:0] IDX_PIN_CFG  = 8'h37;
   localparam logic [7:0] IDX_INT_EN   = 8'h38;
   localparam logic [7:0] IDX_STATUS   = 8'h3A;
   localparam logic [7:0] IDX_INTEL    = 8'h69;
   localparam logic [7:0] IDX_PM1      = 8'h6B;
   localparam logic [7:0] IDX_PM2      = 8'h6C;
   localparam logic [7:0] IDX_STRATEGY = 8'h70;

   // Storage slots of the configuration array
   localparam int NCFG       = 12;
   localparam int S_FILTER   = 0;
   localparam int S_LP       = 1;
   localparam int S_THR      = 2;
   localparam int S_XTHR     = 3;
   localparam int S_PIN_CFG  = 6;
   localparam int S_INT_EN   = 7;
   localparam int S_INTEL    = 8;
   localparam int S_PM1      = 9;
   localparam int S_PM2      = 10;
   localparam int S_STRATEGY = 11;
   localparam logic [7:0] CFG_IDX [NCFG] = '{IDX_FILTER, IDX_LP, IDX_THR, IDX_XTHR, IDX_YTHR, IDX_ZTHR,
                                            IDX_PIN_CFG, IDX_INT_EN, IDX_INTEL, IDX_PM1, IDX_PM2, IDX_STRATEGY};
   localparam logic [7:0] CFG_RST [NCFG] = '{default: 8'h00};
   localparam logic [2:0] FLAGS_RST      = 3'h0;

   // Field positions
   localparam int PM1_RESET_BIT  = 7;
   localparam int PM1_CYCLE_BIT  = 5;
   localparam int PM2_ASTBY_HI   = 5;
   localparam int PM2_ASTBY_LO   = 3;
   localparam int INTEL_EN_BIT   = 7;
   localparam int INTEL_MODE_BIT = 6;
   localparam int WOM_HI         = 7;
   localparam int WOM_LO         = 5;
   localparam int RATE_HI        = 3;
   localparam int RATE_LO        = 0;
   localparam int PIN_SEL_BIT    = 0;
   localparam int PER_AXIS_BIT   = 0;
   localparam logic [2:0] ANY_AXIS_FLAGS = 3'h2;

   // Bus decode
   localparam int IDX_HI = 9;
   localparam int IDX_LO = 2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      MWD_IDLE  = 2'h0,
      MWD_ARM   = 2'h1,
      MWD_WATCH = 2'h3
   } mwd_state_e;
endpackage

// file: mwd_reg_if.sv
`timescale 1ns/1ps
interface mwd_reg_if;
   logic       wr_en;
   logic [7:0] wr_idx;
   logic [7:0] wdata;
   logic       rd_en;
   logic [7:0] rd_idx;
   logic [7:0] rdata;
   modport slave (output wr_en, wr_idx, wdata, rd_en, rd_idx, input rdata);
   modport regs (input wr_en, wr_idx, wdata, rd_en, rd_idx, output rdata);
endinterface

// file: mwd_ahb_slave.sv
`timescale 1ns/1ps
module mwd_ahb_slave
   import mwd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   mwd_reg_if.slave         rb
);
   logic       take;
   logic       addr_ok;
   logic       wr_pend_reg;
   logic       rd_pend_reg;
   logic       rd_ok_reg;
   logic [7:0] wr_idx_reg;
   logic [7:0] rd_idx_reg;

   assign take    = hsel_i & htrans_i[1] & hready_i;
   assign addr_ok = (haddr_i[31:IDX_HI+1] == 22'h0) && (hsize_i == HSIZE_WORD);

   // Address phase capture
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         rd_ok_reg   <= 1'b0;
         wr_idx_reg  <= 8'h00;
         rd_idx_reg  <= 8'h00;
      end else begin
         wr_pend_reg <= take & hwrite_i & addr_ok;
         rd_pend_reg <= take & ~hwrite_i;
         rd_ok_reg   <= addr_ok;
         if (take) begin
            wr_idx_reg <= haddr_i[IDX_HI:IDX_LO];
            rd_idx_reg <= haddr_i[IDX_HI:IDX_LO];
         end
      end
   end

   // Reads take one wait state so a write just before is already stored
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (rd_pend_reg) begin
         hrdata_o <= rd_ok_reg ? {24'h00_0000, rb.rdata} : 32'h0000_0000;
      end
   end

   assign hreadyout_o = ~rd_pend_reg;
   assign hresp_o     = 1'b0;
   assign rb.wr_en    = wr_pend_reg;
   assign rb.wr_idx   = wr_idx_reg;
   assign rb.wdata    = hwdata_i[7:0];
   assign rb.rd_en    = rd_pend_reg & rd_ok_reg;
   assign rb.rd_idx   = rd_idx_reg;
endmodule // mwd_ahb_slave

// file: mwd_axis_cmp.sv
`timescale 1ns/1ps
module mwd_axis_cmp #(
   parameter int unsigned SW        = 16,
   parameter int unsigned THR_SHIFT = 0
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 sample_en_i,
   input  wire logic                 arm_i,
   input  wire logic                 relative_i,
   input  wire logic signed [SW-1:0] sample_i,
   input  wire logic [7:0]           thr_i,
   output logic                      hit_o
);
   logic signed [SW-1:0] ref_reg;
   logic [SW:0]          thr_ext;

   function automatic logic [SW:0] abs_diff(input logic signed [SW-1:0] a, input logic signed [SW-1:0] b);
      logic signed [SW:0] d;
      d = $signed({a[SW-1], a}) - $signed({b[SW-1], b});
      return d[SW] ? $unsigned(-d) : $unsigned(d);
   endfunction

   assign thr_ext = (SW+1)'(thr_i) << THR_SHIFT;

   // Reference: first sample after arming, or each sample in relative mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_reg <= '0;
      end else if (sample_en_i && (arm_i || relative_i)) begin
         ref_reg <= sample_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hit_o <= 1'b0;
      end else begin
         hit_o <= sample_en_i & ~arm_i & (abs_diff(sample_i, ref_reg) > thr_ext);
      end
   end

   a_relative_ref: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sample_en_i && relative_i |=> ref_reg == $past(sample_i))
      else $error("reference not updated in relative mode");
   a_absolute_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !arm_i && !relative_i && !(sample_en_i && arm_i) |=> $stable(ref_reg))
      else $error("reference moved in absolute mode");
endmodule // mwd_axis_cmp

// file: mwd_top.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Full-reset bit write restores all configuration; bit reads back zero.
// - Any-axis: motion on any axis against one shared threshold raises interrupt.
// - Per-axis: each axis compared against its own threshold raises interrupt.
// - Intelligence enable together with the PM1 cycle bit switches detection on; mode bit picks absolute or relative.
// - Motion event detected when data exceeds threshold while wake is active.
// - Motion event drives primary interrupt pin, or selected secondary pin.
// - Relative mode compares each sample with the previous sample.
// - Absolute mode compares with first sample after enabling, held until re-enable.
// - Any-axis motion status reads 010 whatever axis triggered.
module mwd_top
   import mwd_pkg::*;
#(
   parameter int unsigned SW             = 16,
   parameter int unsigned THR_SHIFT      = 0,
   parameter int unsigned LP_BASE_CYCLES = LP_BASE_CYCLES_DEF
) (
   input  wire logic                 SYS_CLK_I,
   input  wire logic                 RST_N_I,
   input  wire logic                 HSEL_I,
   input  wire logic [31:0]          HADDR_I,
   input  wire logic [1:0]           HTRANS_I,
   input  wire logic                 HWRITE_I,
   input  wire logic [2:0]           HSIZE_I,
   input  wire logic [31:0]          HWDATA_I,
   input  wire logic                 HREADY_I,
   output logic                      HREADYOUT_O,
   output logic                      HRESP_O,
   output logic [31:0]               HRDATA_O,
   input  wire logic signed [SW-1:0] ACCEL_X_I,
   input  wire logic signed [SW-1:0] ACCEL_Y_I,
   input  wire logic signed [SW-1:0] ACCEL_Z_I,
   output logic                      INT_O,
   output logic                      SECONDARY_IRQ_PIN_O
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic                 rst_meta_reg;
   logic                 rst_n_reg;
   logic [7:0]           cfg_reg [NCFG];
   logic [2:0]           flags_reg;
   logic [2:0]           flags_next;
   mwd_state_e           state_reg;
   mwd_state_e           state_next;
   logic [31:0]          cnt_reg;
   logic [31:0]          period;
   logic                 sample_en;
   logic                 soft_rst;
   logic                 active;
   logic                 per_axis;
   logic                 relative;
   logic                 pin_sel;
   logic [2:0]           int_en;
   logic [2:0]           stby;
   logic [3:0]           rate;
   logic [2:0]           hit_raw;
   logic [2:0]           hit;
   logic [2:0]           set_flags;
   logic                 flag_clr;
   logic                 irq;
   logic signed [SW-1:0] axis_smp [3];
   logic [7:0]           axis_thr [3];

   mwd_reg_if rb ();

   ////////////////////////////////////////////////////////////////////////////
   // Register index decode
   function automatic logic cfg_hit(input logic [7:0] idx);
      logic found;
      found = 1'b0;
      for (int i = 0; i < NCFG; i++) begin
         if (CFG_IDX[i] == idx) begin
            found = 1'b1;
         end
      end
      return found;
   endfunction

   function automatic logic [3:0] cfg_slot(input logic [7:0] idx);
      logic [3:0] slot;
      slot = 4'h0;
      for (int i = 0; i < NCFG; i++) begin
         if (CFG_IDX[i] == idx) begin
            slot = 4'(i);
         end
      end
      return slot;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave
   mwd_ahb_slave u_bus (
      .clk_i       (SYS_CLK_I),
      .rst_n_i     (rst_n_reg),
      .hsel_i      (HSEL_I),
      .haddr_i     (HADDR_I),
      .htrans_i    (HTRANS_I),
      .hwrite_i    (HWRITE_I),
      .hsize_i     (HSIZE_I),
      .hwdata_i    (HWDATA_I),
      .hready_i    (HREADY_I),
      .hreadyout_o (HREADYOUT_O),
      .hresp_o     (HRESP_O),
      .hrdata_o    (HRDATA_O),
      .rb          (rb.slave)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   assign soft_rst = rb.wr_en && (rb.wr_idx == IDX_PM1) && rb.wdata[PM1_RESET_BIT];

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         for (int i = 0; i < NCFG; i++) begin
            cfg_reg[i] <= CFG_RST[i];
         end
      end else if (soft_rst) begin
         for (int i = 0; i < NCFG; i++) begin
            cfg_reg[i] <= CFG_RST[i];
         end
      end else if (rb.wr_en && cfg_hit(rb.wr_idx)) begin
         cfg_reg[cfg_slot(rb.wr_idx)] <= rb.wdata;
      end
   end

   // Read data; status read clears flags
   always_comb begin
      rb.rdata = 8'h00;
      if (rb.rd_idx == IDX_STATUS) begin
         rb.rdata = {flags_reg, 5'h00};
      end else if (cfg_hit(rb.rd_idx)) begin
         rb.rdata = cfg_reg[cfg_slot(rb.rd_idx)];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field views
   assign active   = cfg_reg[S_INTEL][INTEL_EN_BIT] & cfg_reg[S_PM1][PM1_CYCLE_BIT];
   assign relative = cfg_reg[S_INTEL][INTEL_MODE_BIT];
   assign per_axis = cfg_reg[S_STRATEGY][PER_AXIS_BIT];
   assign pin_sel  = cfg_reg[S_PIN_CFG][PIN_SEL_BIT];
   assign int_en   = cfg_reg[S_INT_EN][WOM_HI:WOM_LO];
   assign stby     = cfg_reg[S_PM2][PM2_ASTBY_HI:PM2_ASTBY_LO];
   assign rate     = cfg_reg[S_LP][RATE_HI:RATE_LO];

   ////////////////////////////////////////////////////////////////////////////
   // Detection sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         MWD_IDLE: begin
            if (active) begin
               state_next = MWD_ARM;
            end
         end
         MWD_ARM: begin
            if (!active) begin
               state_next = MWD_IDLE;
            end else if (sample_en) begin
               state_next = MWD_WATCH;
            end
         end
         MWD_WATCH: begin
            if (!active) begin
               state_next = MWD_IDLE;
            end
         end
         default: begin
            state_next = MWD_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= MWD_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Low-power sample rate divider
   assign period    = 32'(LP_BASE_CYCLES) << rate;
   assign sample_en = (state_reg != MWD_IDLE) && (cnt_reg == period - 32'h0000_0001);

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cnt_reg <= 32'h0000_0000;
      end else if (state_reg == MWD_IDLE || sample_en) begin
         cnt_reg <= 32'h0000_0000;
      end else begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Axis comparators
   assign axis_smp[0] = ACCEL_X_I;
   assign axis_smp[1] = ACCEL_Y_I;
   assign axis_smp[2] = ACCEL_Z_I;

   for (genvar g = 0; g < 3; g++) begin : g_axis
      assign axis_thr[g] = per_axis ? cfg_reg[S_XTHR + g] : cfg_reg[S_THR];

      mwd_axis_cmp #(
         .SW        (SW),
         .THR_SHIFT (THR_SHIFT)
      ) u_cmp (
         .clk_i       (SYS_CLK_I),
         .rst_n_i     (rst_n_reg),
         .sample_en_i (sample_en),
         .arm_i       (state_reg == MWD_ARM),
         .relative_i  (relative),
         .sample_i    (axis_smp[g]),
         .thr_i       (axis_thr[g]),
         .hit_o       (hit_raw[2-g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Motion status flags
   assign hit       = hit_raw & ~stby & {3{active}};
   assign set_flags = per_axis ? hit : ((|hit) ? ANY_AXIS_FLAGS : 3'h0);
   assign flag_clr  = rb.rd_en && (rb.rd_idx == IDX_STATUS);

   always_comb begin
      flags_next = (flag_clr ? 3'h0 : flags_reg) | set_flags;
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         flags_reg <= FLAGS_RST;
      end else if (soft_rst) begin
         flags_reg <= FLAGS_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pins, held until the status is read
   assign irq = |(flags_reg & int_en);

   always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         INT_O  <= 1'b0;
         SECONDARY_IRQ_PIN_O <= 1'b0;
      end else begin
         INT_O  <= irq & ~pin_sel;
         SECONDARY_IRQ_PIN_O <= irq & pin_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!rst_n_reg);

   a_full_reset: assert property (
      soft_rst |=> cfg_reg[S_PM1] == CFG_RST[S_PM1] && cfg_reg[S_INTEL] == CFG_RST[S_INTEL])
      else $error("full reset did not restore defaults");
   a_any_axis_pattern: assert property (
      !per_axis && (|hit) && !soft_rst |=> flags_reg[1])
      else $error("any-axis flag pattern missing");
   a_any_axis_only_mid: assert property (
      !per_axis && (|hit) && flags_reg == 3'h0 && !soft_rst |=> flags_reg == ANY_AXIS_FLAGS)
      else $error("any-axis flags not 010");
   a_per_axis_flag: assert property (
      per_axis && hit[2] && !soft_rst |=> flags_reg[2])
      else $error("per-axis X flag missing");
   a_irq_primary: assert property (
      irq && !pin_sel |=> INT_O && !SECONDARY_IRQ_PIN_O)
      else $error("primary interrupt pin not driven");
   a_irq_secondary: assert property (
      irq && pin_sel |=> SECONDARY_IRQ_PIN_O && !INT_O)
      else $error("secondary interrupt pin not driven");
   a_enable_arms: assert property (
      state_reg == MWD_IDLE && active |=> state_reg == MWD_ARM)
      else $error("enable did not arm detection");
   a_idle_quiet: assert property (
      state_reg == MWD_IDLE |-> !sample_en ##1 hit_raw == 3'h0)
      else $error("sampling while wake inactive");
   a_hit_on_sample: assert property (
      (|hit_raw) |-> $past(sample_en) && $past(state_reg) == MWD_WATCH)
      else $error("hit without a low-power sample");
   a_arm_once: assert property (
      state_reg == MWD_ARM && active && sample_en |=> state_reg == MWD_WATCH)
      else $error("reference not taken on first sample");
   a_soft_reset_quiet: assert property (
      soft_rst |=> flags_reg == FLAGS_RST ##1 flags_reg == FLAGS_RST)
      else $error("flags set after full reset");
   a_standby_blocks: assert property (
      per_axis && stby[2] && !flags_reg[2] |=> !flags_reg[2])
      else $error("flag set on an axis in standby");
   a_set_beats_clear: assert property (
      flag_clr && (|set_flags) && !soft_rst |=> flags_reg == $past(set_flags))
      else $error("clear overrode a new motion flag");
   a_idle_no_count: assert property (
      state_reg == MWD_IDLE |=> cnt_reg == 32'h0000_0000)
      else $error("sample divider ran while idle");

   c_any_axis_irq: cover property (!per_axis && (|hit) ##2 INT_O);
   c_per_axis_irq: cover property (per_axis && (|hit) ##2 (INT_O || SECONDARY_IRQ_PIN_O));
   c_status_clear: cover property (flag_clr && flags_reg != 3'h0);
   c_full_reset: cover property (soft_rst);
   c_relative_hit: cover property (relative && (|hit));
endmodule // mwd_top

// file: mwd_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host processor model: single-word bus master and wake enable sequence
module mwd_host_model
   import mwd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i,
   output logic [31:0]      haddr_o  = 32'h0000_0000,
   output logic [1:0]       htrans_o = 2'h0,
   output logic             hwrite_o = 1'b0,
   output logic [2:0]       hsize_o  = HSIZE_WORD,
   output logic [31:0]      hwdata_o = 32'h0000_0000
);
   ////////////////////////////////////////////////////////////////////////////////
   // One transfer: address phase, then data phase, each held until ready
   task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      htrans_o <= 2'h2;
      haddr_o  <= {22'h00_0000, idx, 2'h0};
      hwrite_o <= wr;
      hsize_o  <= HSIZE_WORD;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      htrans_o <= 2'h0;
      hwdata_o <= {24'h00_0000, wd};
      do @(posedge clk_i); while (hready_i !== 1'b1);
      rd = hrdata_i;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Enable sequence; ax is a one-hot X,Y,Z mask of the axes given the threshold
   task automatic wake_setup(input logic per, input logic mode, input logic pin, input logic [7:0] thr,
                             input logic [2:0] ax, input logic [3:0] rate);
      logic [31:0] d;
      bus_xfer(1'b1, IDX_PM1, 8'h80, d);
      bus_xfer(1'b1, IDX_PM1, 8'h00, d);
      bus_xfer(1'b1, IDX_PM2, 8'h3F, d);
      bus_xfer(1'b1, IDX_FILTER, 8'h07, d);
      bus_xfer(1'b1, IDX_STRATEGY, {7'h00, per}, d);
      bus_xfer(1'b1, IDX_PIN_CFG, {7'h00, pin}, d);
      bus_xfer(1'b1, IDX_INT_EN, 8'hE0, d);
      bus_xfer(1'b1, IDX_THR, thr, d);
      for (int i = 0; i < 3; i++) begin
         bus_xfer(1'b1, IDX_XTHR + 8'(i), ax[i] ? thr : 8'hFF, d);
      end
      bus_xfer(1'b1, IDX_INTEL, {1'b1, mode, 6'h00}, d);
      bus_xfer(1'b1, IDX_LP, {4'h0, rate}, d);
      bus_xfer(1'b1, IDX_PM2, 8'h07, d);
      bus_xfer(1'b1, IDX_PM1, 8'h20, d);
   endtask
endmodule // mwd_host_model

// file: mwd_top_tb_top.sv
`timescale 1ns/1ps
module mwd_top_tb_top
   import mwd_pkg::*;
;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic               hready;
   logic               hresp;
   logic [31:0]        hrdata;
   logic signed [15:0] acc [3] = '{16'h0000, 16'h0000, 16'h0000};
   logic               irq;
   logic               irq2;
   int                 mismatches = 0;
   int                 n_tests = 0;
   int                 cyc = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, timeout, design and host
   initial begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end

   mwd_top #(.LP_BASE_CYCLES(4)) i_mwd_top (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
      .HRESP_O(hresp), .HRDATA_O(hrdata), .ACCEL_X_I(acc[0]), .ACCEL_Y_I(acc[1]), .ACCEL_Z_I(acc[2]),
      .INT_O(irq), .SECONDARY_IRQ_PIN_O(irq2));

   mwd_host_model i_mwd_host_model (
      .clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .haddr_o(haddr), .htrans_o(htrans),
      .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

   ////////////////////////////////////////////////////////////////////////////////
   // Checking helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (mismatches == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] exp_flags(input logic per, input int ax);
      return per ? (32'h0000_0080 >> ax) : 32'h0000_0040;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] rd;
      logic [7:0]  v;
      logic [7:0]  thr;
      logic        per;
      logic        mode;
      logic        eq;
      int          ax;
      int          dlt;
      int          n;
      void'($urandom(32'hc8d4));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      i_mwd_host_model.bus_xfer(1'b0, IDX_THR, 8'h00, rd);
      check(rd, 32'h0000_0000);
      check({31'h0000_0000, hresp}, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         i_mwd_host_model.bus_xfer(1'b1, IDX_THR + 8'(i), v, rd);
         i_mwd_host_model.bus_xfer(1'b0, IDX_THR + 8'(i), 8'h00, rd);
         check(rd, {24'h00_0000, v});
      end
      i_mwd_host_model.bus_xfer(1'b1, 8'h10, 8'hFF, rd);
      i_mwd_host_model.bus_xfer(1'b0, 8'h10, 8'h00, rd);
      check(rd, 32'h0000_0000);
      i_mwd_host_model.bus_xfer(1'b1, IDX_PM1, 8'hA0, rd);
      i_mwd_host_model.bus_xfer(1'b0, IDX_PM1, 8'h00, rd);
      check(rd, 32'h0000_0000);
      i_mwd_host_model.bus_xfer(1'b0, IDX_XTHR, 8'h00, rd);
      check(rd, 32'h0000_0000);
      // Cases: any abs, any rel on second pin, per abs, per rel, any at exact threshold
      for (int c = 0; c < 5; c++) begin
         per  = (c == 2 || c == 3);
         mode = c[0];
         eq   = (c == 4);
         ax   = $urandom_range(2);
         thr  = 8'($urandom_range(100, 10));
         for (int i = 0; i < 3; i++) begin
            acc[i] <= 16'($urandom_range(2000)) - 16'sd1000;
         end
         i_mwd_host_model.wake_setup(per, mode, mode, thr, 3'b001 << ax, 4'(c % 3));
         repeat (30) @(posedge clk);
         dlt = eq ? int'(thr) : int'(thr) + 1 + $urandom_range(50);
         if ($urandom_range(1) == 1) begin
            dlt = -dlt;
         end
         acc[ax] <= acc[ax] + 16'(dlt);
         n = 0;
         while ({irq2, irq} === 2'b00 && n < 100) begin
            @(posedge clk);
            n++;
         end
         check({30'h0000_0000, irq2, irq}, eq ? 32'h0 : (mode ? 32'h2 : 32'h1));
         i_mwd_host_model.bus_xfer(1'b0, IDX_STATUS, 8'h00, rd);
         check(rd, eq ? 32'h0 : exp_flags(per, ax));
         repeat (30) @(posedge clk);
         check({30'h0000_0000, irq2, irq}, (eq || mode) ? 32'h0 : 32'h1);
         i_mwd_host_model.bus_xfer(1'b0, IDX_STATUS, 8'h00, rd);
         check(rd, (eq || mode) ? 32'h0 : exp_flags(per, ax));
      end
      final_report();
   end
endmodule // mwd_top_tb_top
